// File: logic/stpc_pkg.sv
`default_nettype none
package stpc_pkg;
   localparam int CNT_W = 16;
   localparam int CMP_P_W = 8;
   // Register offsets
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_CNT_LO = 4'h2;
   localparam logic [3:0] ADDR_CNT_HI = 4'h3;
   localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
   localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
   localparam logic [3:0] ADDR_CMPP = 4'h6;
   localparam logic [3:0] ADDR_FLAGS = 4'h7;
   // Control 0 fields
   localparam int RUN_BIT = 3;
   // Control 1 fields
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int PIN_HI = 5;
   localparam int PIN_LO = 4;
   localparam int INIT_LVL = 3;
   localparam int POL_BIT = 2;
   localparam int CLR_SEL = 0;
   // Flag fields, write one to clear
   localparam int FLAG_A = 0;
   localparam int FLAG_P = 1;
   // Mode, pin function and edge encodings, reset values
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;
   localparam logic [1:0] PIN_SINGLE_PULSE = 2'h3;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } stpc_bus_t;
endpackage
`default_nettype wire

// File: logic/stpc_timer.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stpc_timer (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic external_trigger_pin_i,
   input wire logic capture_input_pin_i,
   output logic [7:0] rdata_o,
   output logic pulse_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////
   stpc_pkg::stpc_bus_t bus;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   logic counter_run_bit;
   logic [7:0] ctrl1;
   logic [15:0] counter;
   logic [15:0] compare_a_value;
   logic [7:0] compare_p_value;
   logic compare_a_flag;
   logic compare_p_flag;
   logic run_q;
   logic [1:0] trig_sync;
   logic [1:0] cap_sync;
   logic trig_q;
   logic cap_q;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////
   // Decode
   wire [1:0] mode = {ctrl1[stpc_pkg::MODE_HI], ctrl1[stpc_pkg::MODE_LO]};
   wire [1:0] pin_fn = {ctrl1[stpc_pkg::PIN_HI], ctrl1[stpc_pkg::PIN_LO]};
   wire pulse_mode = (mode == stpc_pkg::MODE_PULSE) && (pin_fn == stpc_pkg::PIN_SINGLE_PULSE);
   wire capture_mode = (mode == stpc_pkg::MODE_CAPTURE);
   wire wr_c0 = bus.wr && (bus.addr == stpc_pkg::ADDR_CTRL0);
   wire wr_c1 = bus.wr && (bus.addr == stpc_pkg::ADDR_CTRL1);
   wire wr_al = bus.wr && (bus.addr == stpc_pkg::ADDR_CMPA_LO);
   wire wr_ah = bus.wr && (bus.addr == stpc_pkg::ADDR_CMPA_HI);
   wire wr_p = bus.wr && (bus.addr == stpc_pkg::ADDR_CMPP);
   wire wr_fl = bus.wr && (bus.addr == stpc_pkg::ADDR_FLAGS);
   wire run_rise = counter_run_bit && !run_q;

   wire trig_s = trig_sync[1];
   wire cap_s = cap_sync[1];
   wire trig_rise = trig_s && !trig_q;
   wire cap_rise = cap_s && !cap_q;
   wire cap_fall = !cap_s && cap_q;
   wire cap_edge = (pin_fn == stpc_pkg::EDGE_RISE) ? cap_rise :
                   (pin_fn == stpc_pkg::EDGE_FALL) ? cap_fall :
                   (pin_fn == stpc_pkg::EDGE_BOTH) ? (cap_rise || cap_fall) : 1'b0;
   wire capture_hit = capture_mode && counter_run_bit && cap_edge;

   wire match_a = pulse_mode && counter_run_bit && !run_rise && (counter == compare_a_value);
   wire [7:0] top = counter[15:8];
   wire cnt_max = (counter == 16'hffff);
   wire match_p = capture_mode && counter_run_bit && !run_rise &&
                  ((compare_p_value == stpc_pkg::RESET_BYTE) ? cnt_max :
                   ((top == compare_p_value) && (counter[7:0] == 8'hff)));
   wire trig_start = pulse_mode && trig_rise && !counter_run_bit;

   ////////////////////////////////////////////////////////////////
   // Synchronisers and edge history
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         trig_sync <= 2'h0;
         cap_sync <= 2'h0;
         trig_q <= 1'b0;
         cap_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[0], external_trigger_pin_i};
         cap_sync <= {cap_sync[0], capture_input_pin_i};
         trig_q <= trig_s;
         cap_q <= cap_s;
         run_q <= counter_run_bit;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         counter_run_bit <= 1'b0;
         ctrl1 <= stpc_pkg::RESET_BYTE;
         compare_p_value <= stpc_pkg::RESET_BYTE;
      end else begin
         if (match_a) begin
            counter_run_bit <= 1'b0;
         end else if (trig_start) begin
            counter_run_bit <= 1'b1;
         end else if (wr_c0) begin
            counter_run_bit <= bus.wdata[stpc_pkg::RUN_BIT];
         end
         if (wr_c1) begin
            ctrl1 <= bus.wdata;
         end
         if (wr_p) begin
            compare_p_value <= bus.wdata;
         end
      end
   end

   // Compare A register, also capture target
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         compare_a_value <= stpc_pkg::RESET_WORD;
      end else if (capture_hit) begin
         compare_a_value <= counter;
      end else if (wr_al) begin
         compare_a_value[7:0] <= bus.wdata;
      end else if (wr_ah) begin
         compare_a_value[15:8] <= bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         counter <= stpc_pkg::RESET_WORD;
      end else if (run_rise) begin
         counter <= stpc_pkg::RESET_WORD;
      end else if (match_p) begin
         counter <= stpc_pkg::RESET_WORD;
      end else if (counter_run_bit && !match_a) begin
         counter <= counter + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Flags, set beats write-one clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
      end else begin
         if (match_a || capture_hit) begin
            compare_a_flag <= 1'b1;
         end else if (wr_fl && bus.wdata[stpc_pkg::FLAG_A]) begin
            compare_a_flag <= 1'b0;
         end
         if (match_p) begin
            compare_p_flag <= 1'b1;
         end else if (wr_fl && bus.wdata[stpc_pkg::FLAG_P]) begin
            compare_p_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pulse output and interrupt
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pulse_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         if (pulse_mode) begin
            pulse_o <= (counter_run_bit && !match_a) ? ctrl1[stpc_pkg::INIT_LVL] :
                       !ctrl1[stpc_pkg::INIT_LVL];
         end else begin
            pulse_o <= 1'b0;
         end
         irq_o <= compare_a_flag || compare_p_flag;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      case (bus.addr)
         stpc_pkg::ADDR_CTRL0: next_rdata = {4'h0, counter_run_bit, 3'h0};
         stpc_pkg::ADDR_CTRL1: next_rdata = ctrl1;
         stpc_pkg::ADDR_CNT_LO: next_rdata = counter[7:0];
         stpc_pkg::ADDR_CNT_HI: next_rdata = counter[15:8];
         stpc_pkg::ADDR_CMPA_LO: next_rdata = compare_a_value[7:0];
         stpc_pkg::ADDR_CMPA_HI: next_rdata = compare_a_value[15:8];
         stpc_pkg::ADDR_CMPP: next_rdata = compare_p_value;
         stpc_pkg::ADDR_FLAGS: next_rdata = {6'h00, compare_p_flag, compare_a_flag};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (bus.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // stpc_timer
`default_nettype wire

// File: dv/stpc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module stpc_pins_model (
   input wire logic core_clk_i,
   input wire logic fire_i,
   input wire logic cap_lvl_i,
   output logic trig_o,
   output logic cap_o
);
   logic [1:0] hold = 2'h0;
   always_ff @(posedge core_clk_i) begin
      if (fire_i) hold <= 2'h3;
      else if (hold != 2'h0) hold <= hold - 2'h1;
   end
   assign trig_o = fire_i || hold != 2'h0;
   assign cap_o = cap_lvl_i;
endmodule // stpc_pins_model
`default_nettype wire

// File: dv/stpc_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module stpc_timer_chk (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic external_trigger_pin_i,
   input wire logic capture_input_pin_i,
   input wire logic [7:0] rdata_o,
   input wire logic pulse_o,
   input wire logic irq_o
);
   logic [7:0] c1;
   logic r;
   wire logic w0 = wr_i && addr_i == 4'h0;
   wire logic wf = wr_i && addr_i == 4'h7;
   wire logic pmd = c1[7:6] == 2'h2;
   wire logic pm = pmd && c1[5:4] == 2'h3 && c1[3];
   wire logic cm = c1[7:4] == 4'h4 && r;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         c1 <= 8'h00;
         r <= 1'b0;
      end else begin
         if (wr_i && addr_i == 4'h1) c1 <= wdata_i;
         if (w0) r <= wdata_i[3];
      end
   end
   //////////////////////////////////////////
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_run_start: assert property (w0 && wdata_i[3] && pm |-> ##[1:2] pulse_o)
      else $error("no start");
   a_sw_stop: assert property (w0 && !wdata_i[3] && pm && pulse_o |-> ##[1:2] !pulse_o)
      else $error("no stop");
   a_end_irq: assert property (pm && $fell(pulse_o) && !$past(w0) && !$past(w0, 2)
      |-> ##[1:2] irq_o) else $error("no irq at end");
   a_end_low: assert property (pm && $fell(pulse_o) && !$past(w0) && !$past(w0, 2)
      |=> !pulse_o [*2]) else $error("pulse restarted");
   a_trig_start: assert property (pm && !pulse_o && $rose(external_trigger_pin_i)
      |-> ##[3:6] pulse_o) else $error("no trigger");
   a_no_out: assert property (!pmd && !$past(pmd) |-> !pulse_o)
      else $error("output outside pulse");
   a_cap_irq: assert property (cm && $rose(capture_input_pin_i) |-> ##[3:6] irq_o)
      else $error("no capture irq");
   a_irq_hold: assert property ($fell(irq_o) |-> $past(wf) || $past(wf, 2))
      else $error("irq dropped");
endmodule // stpc_timer_chk
bind stpc_timer stpc_timer_chk stpc_timer_chk_i (.core_clk_i, .rst_n_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .external_trigger_pin_i, .capture_input_pin_i, .rdata_o, .pulse_o, .irq_o);
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fire = 1'b0;
   logic cap = 1'b0;
   logic trig;
   logic capo;
   logic [7:0] rdata;
   logic pulse;
   logic irq;
   int miscompares = 0;
   int compares = 0;
   always #5 clk = ~clk;
   stpc_pins_model stpc_pins_model_i (.core_clk_i(clk), .fire_i(fire), .cap_lvl_i(cap),
      .trig_o(trig), .cap_o(capo));
   stpc_timer stpc_timer_i (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .external_trigger_pin_i(trig), .capture_input_pin_i(capo),
      .rdata_o(rdata), .pulse_o(pulse), .irq_o(irq));
   //////////////////////////////////////////
   task automatic complete_run();
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrb(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdb(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic cnt(input logic v, output int n);
      n = 0;
      #1;
      while (pulse === v && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 300) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic pulse_run(input logic [7:0] a, input logic by_pin, output int w);
      int n;
      wrb(4'h4, a);
      if (by_pin) begin
         @(posedge clk);
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
      end else wrb(4'h0, 8'h08);
      cnt(1'b0, n);
      cnt(1'b1, w);
      rdb(4'h7, 8'h01);
      rdb(4'h0, 8'h00);
      wrb(4'h7, 8'h01);
   endtask
   task automatic sc_pulse();
      int w1;
      int w2;
      int w3;
      wrb(4'h1, 8'hb9);
      wrb(4'h6, 8'h01);
      pulse_run(8'h05, 1'b0, w1);
      pulse_run(8'h09, 1'b0, w2);
      pulse_run(8'h05, 1'b1, w3);
      chk(8'(w2 - w1), 8'h04);
      chk(8'(w3 - w1), 8'h00);
   endtask
   task automatic sc_stop();
      wrb(4'h4, 8'hff);
      wrb(4'h0, 8'h08);
      repeat (3) @(posedge clk);
      wrb(4'h0, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, pulse}, 8'h00);
      rdb(4'h7, 8'h00);
   endtask
   task automatic sc_capture();
      for (int f = 0; f < 4; f++) begin
         wrb(4'h1, {2'h1, 2'(f), 4'h0});
         wrb(4'h0, 8'h00);
         wrb(4'h0, 8'h08);
         cap <= 1'b1;
         repeat (6) @(posedge clk);
         rdb(4'h7, {7'h0, f == 0 || f == 2});
         wrb(4'h7, 8'h01);
         cap <= 1'b0;
         repeat (6) @(posedge clk);
         rdb(4'h7, {7'h0, f == 1 || f == 2});
         wrb(4'h7, 8'h01);
      end
   endtask
   task automatic sc_period();
      wrb(4'h0, 8'h00);
      wrb(4'h0, 8'h08);
      repeat (200) @(posedge clk);
      rdb(4'h7, 8'h00);
      repeat (400) @(posedge clk);
      rdb(4'h7, 8'h02);
      chk({7'h0, irq}, 8'h01);
      wrb(4'h7, 8'h02);
      wrb(4'h6, 8'h00);
      wrb(4'h0, 8'h00);
      wrb(4'h0, 8'h08);
      repeat (600) @(posedge clk);
      rdb(4'h7, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      sc_pulse();
      sc_stop();
      sc_capture();
      sc_period();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
